// ### src/ocsr_pkg.sv
// Package of offsets, field layouts and reset values for the output/status register bank
// Operation
// R1: Each clock output register holds power-down D7, format D4, amplitude D3:D2.
// R2: Output registers at 0x28-0x2A, 0x30-0x32, 0x38-0x39, 0x40-0x41, auxiliary 0x4B.
// R3: Clock output powered up when its power-down bit is 0; resets to 0.
// R4: Auxiliary output power-down bit D7: 0 up, 1 down; resets to 0.
// R5: Amplitude 00=350mV, 01=500mV, 10=700mV, 11=850mV in both formats.
// R6: Clock output amplitude resets to 01; auxiliary amplitude resets to 00.
// R7: Clock output format bit: 0 LVDS, 1 LVPECL; resets to 0.
// R8: Auxiliary format D5:D4: 00 LVDS, 01 LVPECL, 1x complementary CMOS; resets 10.
// R9: Enables 0x4C, latched 0x50, live 0x51 with selection D6, VCO flag D2 of 0x53.
// R10: Enabled latched fault drives the active-low interrupt output low.
// R11: Latched bit holds fault since last clear; writing 1 clears it and its interrupt.
// R12: Live lock bits read 0 while lock is lost, 1 otherwise.
// R13: Selection bit shows the chosen reference: 0 input 0, 1 input 1.
// R14: Reserved bits read zero and ignore writes.
// R15: Status registers have no meaningful reset value; software clears latches first.
package ocsr_pkg;
   localparam int NUM_OUT = 10;
   localparam logic [7:0] OFS_A0 = 8'h28;
   localparam logic [7:0] OFS_A1 = 8'h29;
   localparam logic [7:0] OFS_A2 = 8'h2A;
   localparam logic [7:0] OFS_B0 = 8'h30;
   localparam logic [7:0] OFS_B1 = 8'h31;
   localparam logic [7:0] OFS_B2 = 8'h32;
   localparam logic [7:0] OFS_C0 = 8'h38;
   localparam logic [7:0] OFS_C1 = 8'h39;
   localparam logic [7:0] OFS_D0 = 8'h40;
   localparam logic [7:0] OFS_D1 = 8'h41;
   localparam logic [7:0] OFS_AUX = 8'h4B;
   localparam logic [7:0] OFS_IRQ_EN = 8'h4C;
   localparam logic [7:0] OFS_LATCHED = 8'h50;
   localparam logic [7:0] OFS_LIVE = 8'h51;
   localparam logic [7:0] OFS_VCO = 8'h53;
   localparam logic [7:0] OUT_OFS [NUM_OUT] = '{OFS_A0, OFS_A1, OFS_A2, OFS_B0, OFS_B1,
      OFS_B2, OFS_C0, OFS_C1, OFS_D0, OFS_D1};
   // Field positions
   localparam int PD_BIT = 7;
   localparam int FMT_BIT = 4;
   localparam int FMT_AUX_LSB = 4;
   localparam int AMP_LSB = 2;
   localparam int SEL_BIT = 6;
   localparam int VCO_BIT = 2;
   localparam int STAT_W = 6;
   // Reset values
   localparam logic RST_PD = 1'b0;
   localparam logic RST_FMT = 1'b0;
   localparam logic [1:0] RST_AMP = 2'h1;
   localparam logic [1:0] RST_AUX_AMP = 2'h0;
   localparam logic [1:0] RST_AUX_FMT = 2'h2;
   localparam logic [5:0] RST_IRQ_EN = 6'h00;
   localparam logic [5:0] RST_LATCHED = 6'h3F;
   // Encodings
   typedef enum logic [1:0] {
      OCSR_AMP_350MV = 2'h0,
      OCSR_AMP_500MV = 2'h1,
      OCSR_AMP_700MV = 2'h2,
      OCSR_AMP_850MV = 2'h3
   } ocsr_amp_e;
   typedef enum logic [1:0] {
      OCSR_AUX_LVDS = 2'h0,
      OCSR_AUX_LVPECL = 2'h1,
      OCSR_AUX_CMOS = 2'h2,
      OCSR_AUX_CMOS2 = 2'h3
   } ocsr_auxfmt_e;
   typedef struct packed {
      logic powerdown;
      logic lvpecl;
      ocsr_amp_e amp;
   } ocsr_out_s;
   typedef struct packed {
      logic powerdown;
      ocsr_auxfmt_e fmt;
      ocsr_amp_e amp;
   } ocsr_aux_s;
   // Status bit order, D5..D0
   typedef struct packed {
      logic synth_lock;
      logic vcxo_lock;
      logic ref_valid;
      logic not_holdover;
      logic input1_active;
      logic input0_active;
   } ocsr_stat_s;
endpackage : ocsr_pkg

// ### src/ocsr_regs.sv
// Output configuration and status register bank
`timescale 1ns/1ps
module ocsr_regs (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire ocsr_pkg::ocsr_stat_s live_status,
   input wire logic selected_input,
   input wire logic vco_state_flag,
   output ocsr_pkg::ocsr_out_s [ocsr_pkg::NUM_OUT-1:0] clock_output,
   output ocsr_pkg::ocsr_aux_s aux_clock_output,
   output logic irq_out_n
);
   import ocsr_pkg::*;

   ocsr_out_s [NUM_OUT-1:0] out_cfg_r;
   ocsr_aux_s aux_cfg_r;
   logic [5:0] irq_en_r;
   logic [5:0] latched_r;
   logic [5:0] latched_nxt;
   logic [5:0] live_v;
   logic [7:0] rdata_nxt;
   logic wr_latched;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign live_v = live_status;
   assign wr_latched = clk_en && reg_wr && hit(reg_addr, OFS_LATCHED);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               out_cfg_r[gi].powerdown <= RST_PD; // R3
               out_cfg_r[gi].lvpecl <= RST_FMT; // R7
               out_cfg_r[gi].amp <= ocsr_amp_e'(RST_AMP); // R6
            end else if (clk_en && reg_wr && hit(reg_addr, OUT_OFS[gi])) begin // R2
               out_cfg_r[gi].powerdown <= reg_wdata[PD_BIT]; // R1
               out_cfg_r[gi].lvpecl <= reg_wdata[FMT_BIT]; // R1
               out_cfg_r[gi].amp <= ocsr_amp_e'(reg_wdata[AMP_LSB +: 2]); // R5
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aux_cfg_r.powerdown <= RST_PD; // R4
         aux_cfg_r.fmt <= ocsr_auxfmt_e'(RST_AUX_FMT); // R8
         aux_cfg_r.amp <= ocsr_amp_e'(RST_AUX_AMP); // R6
      end else if (clk_en && reg_wr && hit(reg_addr, OFS_AUX)) begin
         aux_cfg_r.powerdown <= reg_wdata[PD_BIT]; // R4
         aux_cfg_r.fmt <= ocsr_auxfmt_e'(reg_wdata[FMT_AUX_LSB +: 2]); // R8
         aux_cfg_r.amp <= ocsr_amp_e'(reg_wdata[AMP_LSB +: 2]); // R5
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_en_r <= RST_IRQ_EN;
      end else if (clk_en && reg_wr && hit(reg_addr, OFS_IRQ_EN)) begin
         irq_en_r <= reg_wdata[STAT_W-1:0]; // R9 R14
      end
   end

   // Latches hold a fault (0) until written with 1; a fault in the clear cycle wins
   always_comb begin
      latched_nxt = latched_r;
      if (wr_latched) begin
         latched_nxt = latched_r | reg_wdata[STAT_W-1:0]; // R11
      end
      latched_nxt = latched_nxt & live_v; // R11 R12
   end

   // Reset value is only a defined start; software must clear before trusting it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         latched_r <= RST_LATCHED; // R15
      end else if (clk_en) begin
         latched_r <= latched_nxt;
      end
   end

   // Interrupt is a registered function of the next latch value (latched_nxt) and enables
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_out_n <= 1'b1;
      end else if (clk_en) begin
         irq_out_n <= ~|(~latched_nxt & irq_en_r); // R10
      end
   end

   always_comb begin
      rdata_nxt = 8'h00; // R14
      for (int i = 0; i < NUM_OUT; i++) begin
         if (hit(reg_addr, OUT_OFS[i])) begin
            rdata_nxt[PD_BIT] = out_cfg_r[i].powerdown;
            rdata_nxt[FMT_BIT] = out_cfg_r[i].lvpecl;
            rdata_nxt[AMP_LSB +: 2] = out_cfg_r[i].amp;
         end
      end
      case (reg_addr)
         OFS_AUX: begin
            rdata_nxt[PD_BIT] = aux_cfg_r.powerdown;
            rdata_nxt[FMT_AUX_LSB +: 2] = aux_cfg_r.fmt;
            rdata_nxt[AMP_LSB +: 2] = aux_cfg_r.amp;
         end
         OFS_IRQ_EN: rdata_nxt[STAT_W-1:0] = irq_en_r; // R9
         OFS_LATCHED: rdata_nxt[STAT_W-1:0] = latched_r; // R9
         OFS_LIVE: begin
            rdata_nxt[STAT_W-1:0] = live_v; // R12
            rdata_nxt[SEL_BIT] = selected_input; // R13
         end
         OFS_VCO: rdata_nxt[VCO_BIT] = vco_state_flag; // R9
         default: ;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en && reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

   assign clock_output = out_cfg_r;
   assign aux_clock_output = aux_cfg_r;

   // Reset values are checked at the first edge after release
   reset_amp_a: assert property (@(posedge mclk) $rose(reset_n) |-> // R6
      clock_output[0].amp == OCSR_AMP_500MV && aux_clock_output.fmt == OCSR_AUX_CMOS)
      else $error("Output reset values wrong");

   write_cfg_a: assert property (@(posedge mclk) disable iff (!reset_n) // R1
      clk_en && reg_wr && reg_addr == OFS_A0 |=> clock_output[0].powerdown ==
      $past(reg_wdata[7]) && clock_output[0].amp == $past(reg_wdata[3:2]))
      else $error("Output config write lost");

   aux_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
      clk_en && reg_wr && reg_addr == OFS_AUX |=> aux_clock_output.fmt == $past(reg_wdata[5:4])
      && aux_clock_output.powerdown == $past(reg_wdata[7]))
      else $error("Aux config write lost");

   fault_latch_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
      clk_en && !live_v[0] |=> !latched_r[0])
      else $error("Fault not latched");

   hold_latch_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
      clk_en && !latched_r[1] && !wr_latched |=> !latched_r[1])
      else $error("Latch released without clear");

   irq_assert_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
      clk_en && !latched_r[5] && irq_en_r[5] && !wr_latched && !(reg_wr && reg_addr == OFS_IRQ_EN)
      |=> !irq_out_n)
      else $error("Interrupt not raised");

   irq_quiet_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
      clk_en && irq_en_r == 6'h00 && !(reg_wr && reg_addr == OFS_IRQ_EN) |=> irq_out_n)
      else $error("Interrupt without enable");

   reserved_zero_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
      clk_en && reg_rd && (reg_addr == OFS_IRQ_EN || reg_addr == OFS_LATCHED) |=>
      reg_rdata[7:6] == 2'h0)
      else $error("Reserved bits not zero");

   live_sel_a: assert property (@(posedge mclk) disable iff (!reset_n) // R13
      clk_en && reg_rd && reg_addr == OFS_LIVE |=> reg_rdata[6] == $past(selected_input))
      else $error("Selection bit wrong");

   // Every output register is checked on its own: write, hold, reset and read back
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_out_chk
         out_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // R1 R2
            clk_en && reg_wr && reg_addr == OUT_OFS[gi] |=> clock_output[gi] ==
            {$past(reg_wdata[PD_BIT]), $past(reg_wdata[FMT_BIT]), $past(reg_wdata[3:2])})
            else $error("Output register write lost");

         out_pd_a: assert property (@(posedge mclk) disable iff (!reset_n) // R3
            clk_en && reg_wr && reg_addr == OUT_OFS[gi] |=>
            clock_output[gi].powerdown == $past(reg_wdata[7]))
            else $error("Output power-down write lost");

         out_fmt_a: assert property (@(posedge mclk) disable iff (!reset_n) // R7
            clk_en && reg_wr && reg_addr == OUT_OFS[gi] |=>
            clock_output[gi].lvpecl == $past(reg_wdata[4]))
            else $error("Output format write lost");

         out_amp_a: assert property (@(posedge mclk) disable iff (!reset_n) // R5
            clk_en && reg_wr && reg_addr == OUT_OFS[gi] |=>
            clock_output[gi].amp == $past(reg_wdata[3:2]))
            else $error("Output amplitude write lost");

         out_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R3 R7
            !(clk_en && reg_wr && reg_addr == OUT_OFS[gi]) |=> $stable(clock_output[gi]))
            else $error("Output register changed without write");

         out_reset_a: assert property (@(posedge mclk) $rose(reset_n) |-> // R3 R6 R7
            clock_output[gi] == {RST_PD, RST_FMT, RST_AMP})
            else $error("Output register reset value wrong");

         out_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R1 R14
            clk_en && reg_rd && reg_addr == OUT_OFS[gi] |=> reg_rdata ==
            {$past(clock_output[gi].powerdown), 2'h0, $past(clock_output[gi].lvpecl),
            $past(clock_output[gi].amp), 2'h0})
            else $error("Output register read wrong");
      end
   endgenerate

   // Auxiliary output
   aux_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R4 R8
      !(clk_en && reg_wr && reg_addr == OFS_AUX) |=> $stable(aux_clock_output))
      else $error("Aux register changed without write");

   aux_reset_a: assert property (@(posedge mclk) $rose(reset_n) |-> // R4 R6 R8
      aux_clock_output == {RST_PD, RST_AUX_FMT, RST_AUX_AMP})
      else $error("Aux register reset value wrong");

   aux_pd_a: assert property (@(posedge mclk) disable iff (!reset_n) // R4
      clk_en && reg_wr && reg_addr == OFS_AUX |=>
      aux_clock_output.powerdown == $past(reg_wdata[PD_BIT]))
      else $error("Aux power-down write lost");

   aux_amp_a: assert property (@(posedge mclk) disable iff (!reset_n) // R5
      clk_en && reg_wr && reg_addr == OFS_AUX |=>
      aux_clock_output.amp == $past(reg_wdata[3:2]))
      else $error("Aux amplitude write lost");

   // Either code with the upper bit set selects the complementary single-ended pair
   aux_cmos_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8
      clk_en && reg_wr && reg_addr == OFS_AUX && reg_wdata[5] |=>
      aux_clock_output.fmt inside {OCSR_AUX_CMOS, OCSR_AUX_CMOS2})
      else $error("Aux single-ended code lost");

   aux_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R8 R14
      clk_en && reg_rd && reg_addr == OFS_AUX |=> reg_rdata ==
      {$past(aux_clock_output.powerdown), 1'b0, $past(aux_clock_output.fmt),
      $past(aux_clock_output.amp), 2'h0})
      else $error("Aux register read wrong");

   // Interrupt enables
   irq_en_write_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9 R14
      clk_en && reg_wr && reg_addr == OFS_IRQ_EN |=> irq_en_r == $past(reg_wdata[5:0]))
      else $error("Interrupt enable write lost");

   irq_en_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9
      !(clk_en && reg_wr && reg_addr == OFS_IRQ_EN) |=> $stable(irq_en_r))
      else $error("Interrupt enable changed without write");

   irq_en_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9 R14
      clk_en && reg_rd && reg_addr == OFS_IRQ_EN |=> reg_rdata == {2'h0, $past(irq_en_r)})
      else $error("Interrupt enable read wrong");

   irq_en_reset_a: assert property (@(posedge mclk) $rose(reset_n) |-> // R9
      irq_en_r == RST_IRQ_EN && irq_out_n)
      else $error("Interrupt reset state wrong");

   // Status latches start from a known value, which software still has to clear
   stat_reset_a: assert property (@(posedge mclk) $rose(reset_n) |-> // R15
      latched_r == RST_LATCHED && reg_rdata == 8'h00)
      else $error("Status reset state wrong");

   // Each latch bit: a fault sets it, only a clear while the live bit is good releases it
   generate
      for (gi = 0; gi < STAT_W; gi++) begin : g_stat_chk
         latch_set_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11 R12
            clk_en && !live_v[gi] |=> !latched_r[gi])
            else $error("Status fault not latched");

         latch_keep_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
            clk_en && !latched_r[gi] && !(wr_latched && reg_wdata[gi]) |=> !latched_r[gi])
            else $error("Status latch released without clear");

         latch_clear_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
            clk_en && wr_latched && reg_wdata[gi] && live_v[gi] |=> latched_r[gi])
            else $error("Status latch not cleared");

         latch_good_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
            clk_en && latched_r[gi] && live_v[gi] |=> latched_r[gi])
            else $error("Status latch fell without fault");

         irq_bit_a: assert property (@(posedge mclk) disable iff (!reset_n) // R10
            clk_en && !live_v[gi] && irq_en_r[gi] |=> !irq_out_n)
            else $error("Enabled fault gave no interrupt");
      end
   endgenerate

   // A full clear with every live bit good must release the interrupt
   irq_release_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
      wr_latched && reg_wdata[5:0] == 6'h3F && &live_v |=> irq_out_n)
      else $error("Interrupt not released by clear");

   // A low enable must freeze every register, status and interrupt included
   freeze_a: assert property (@(posedge mclk) disable iff (!reset_n) // R11
      !clk_en |=> $stable(latched_r) && $stable(irq_en_r) && $stable(irq_out_n)
      && $stable(reg_rdata) && $stable(clock_output) && $stable(aux_clock_output))
      else $error("State moved while enable low");

   // Read paths
   latched_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9 R11
      clk_en && reg_rd && reg_addr == OFS_LATCHED |=> reg_rdata == {2'h0, $past(latched_r)})
      else $error("Latched status read wrong");

   live_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R12 R13
      clk_en && reg_rd && reg_addr == OFS_LIVE |=> reg_rdata ==
      {1'b0, $past(selected_input), $past(live_status)})
      else $error("Live status read wrong");

   vco_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R9 R14
      clk_en && reg_rd && reg_addr == OFS_VCO |=>
      reg_rdata == {5'h00, $past(vco_state_flag), 2'h0})
      else $error("VCO status read wrong");

   // Holes in the map read as zero
   unmapped_read_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
      clk_en && reg_rd && reg_addr inside {8'h2B, 8'h2F, 8'h33, 8'h3A, 8'h42, 8'h4A, 8'h4D,
      8'h52, 8'h54} |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero");

   // Read-only status ignores writes, so good latches stay good
   live_ro_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
      clk_en && reg_wr && reg_addr == OFS_LIVE && &live_v && &latched_r |=> &latched_r)
      else $error("Write to live status had effect");

   // Read data is held between reads so a slow master may sample it late
   rdata_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // R14
      !(clk_en && reg_rd) |=> $stable(reg_rdata))
      else $error("Read data changed without read");
endmodule : ocsr_regs

// ### bench/tb_top.sv
// Self-checking testbench for the output configuration and status register bank
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_top;
   import ocsr_pkg::*;
   logic mclk, reset_n, clk_en, reg_wr, reg_rd, selected_input, vco_state_flag, irq_out_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   ocsr_stat_s live_status;
   ocsr_out_s [NUM_OUT-1:0] clock_output;
   ocsr_aux_s aux_clock_output;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] e;
   logic [5:0] m;
   ocsr_regs dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .live_status(live_status), .selected_input(selected_input),
      .vco_state_flag(vco_state_flag), .clock_output(clock_output),
      .aux_clock_output(aux_clock_output), .irq_out_n(irq_out_n));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task print_verdict;
      if (num_errors == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : print_verdict
   // Strobe held for exactly one taken edge, then one idle edge before the next request
   task wr(input logic [7:0] ad, input logic [7:0] wd);
      reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= wd;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr
   // Read data is registered and holds, so it is checked an edge after the taken one
   task rd(input logic [7:0] ad, input logic [7:0] ex);
      reg_rd <= 1'b1; reg_addr <= ad;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      `CHK($sformatf("reg %h", ad), reg_rdata, ex)
   endtask : rd
   // Pattern per output: amplitude walks all four codes over the first outputs
   function automatic logic [7:0] out_val(input int i);
      logic [3:0] b;
      b = 4'(i);
      return {b[2], 2'b00, b[0] ^ b[1], b[1:0], 2'b00};
   endfunction : out_val
   task check_reset;
      for (int i = 0; i < NUM_OUT; i++) begin
         `CHK("out port", clock_output[i], 4'h1)
         rd(OUT_OFS[i], 8'h04);
      end
      `CHK("aux port", aux_clock_output, 5'h08)
      rd(OFS_AUX, 8'h20);
      rd(OFS_IRQ_EN, 8'h00);
      `CHK("irq", irq_out_n, 1'b1)
   endtask : check_reset
   initial begin
      reset_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 8'h00; live_status = 6'h3F; selected_input = 1'b0; vco_state_flag = 1'b0;
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      check_reset;
      // Reserved bits are written as ones to prove they stay zero
      for (int i = 0; i < NUM_OUT; i++) wr(OUT_OFS[i], out_val(i) | 8'h63);
      for (int i = 0; i < NUM_OUT; i++) begin
         e = out_val(i);
         rd(OUT_OFS[i], e);
         `CHK("out port", clock_output[i], {e[7], e[4], e[3:2]})
      end
      for (int f = 0; f < 4; f++) begin
         e = {f[0], 1'b0, f[1:0], 2'(3 - f), 2'b00};
         wr(OFS_AUX, e | 8'h43);
         rd(OFS_AUX, e);
         `CHK("aux port", aux_clock_output, {e[7], e[5:4], e[3:2]})
      end
      wr(8'h2B, 8'hFF);
      rd(8'h2B, 8'h00);
      clk_en <= 1'b0;
      wr(OFS_D1, 8'h00);
      clk_en <= 1'b1;
      rd(OFS_D1, out_val(9));
      live_status <= 6'h2A; selected_input <= 1'b1; vco_state_flag <= 1'b1;
      @(posedge mclk);
      wr(OFS_LIVE, 8'h00);
      rd(OFS_LIVE, 8'h6A);
      rd(OFS_VCO, 8'h04);
      selected_input <= 1'b0; vco_state_flag <= 1'b0; live_status <= 6'h3F;
      @(posedge mclk);
      rd(OFS_LIVE, 8'h3F);
      rd(OFS_VCO, 8'h00);
      rd(OFS_LATCHED, 8'h2A);
      wr(OFS_LATCHED, 8'hFF);
      rd(OFS_LATCHED, 8'h3F);
      wr(OFS_IRQ_EN, 8'hFF);
      rd(OFS_IRQ_EN, 8'h3F);
      for (int b = 0; b < 6; b++) begin
         m = 6'h01 << b;
         live_status <= ~m;
         @(posedge mclk);
         live_status <= 6'h3F;
         @(posedge mclk);
         `CHK("irq", irq_out_n, 1'b0)
         rd(OFS_LATCHED, {2'b00, ~m});
         `CHK("irq", irq_out_n, 1'b0)
         wr(OFS_LATCHED, {2'b00, m});
         `CHK("irq", irq_out_n, 1'b1)
         rd(OFS_LATCHED, 8'h3F);
      end
      // Masked fault latches but must leave the interrupt alone
      wr(OFS_IRQ_EN, 8'h3E);
      live_status <= 6'h3E;
      repeat (2) @(posedge mclk);
      `CHK("irq", irq_out_n, 1'b1)
      wr(OFS_LATCHED, 8'h01);
      rd(OFS_LATCHED, 8'h3E);
      live_status <= 6'h3F;
      @(posedge mclk);
      wr(OFS_LATCHED, 8'h01);
      rd(OFS_LATCHED, 8'h3F);
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      check_reset;
      print_verdict;
   end
   initial begin
      repeat (4000) @(posedge mclk);
      num_errors++;
      print_verdict;
   end
endmodule : tb_top
